// ===== stc_cache.sv
// Function
// - Every write without an exception goes to storage, and to cache on a hit.
// - Write completes once controller accepts it.
// - Write miss allocates no line.
// - Only fetch or program read misses fill.
// - Other read misses bypass the cache.
// - Each request carries its requester type.
// - Invalidation latched in pend_ff beats competing processor request.
// - On invalid line, release bus, latch address.
// - Invalidate next cycle; controller ignores requests.
// - Three checks flag unauthorised access, write or fetch.
// - Positions: free, controlled, read-only, forbidden.
// - Access key per 8-Kbyte block.
// - Read-only key per 4-Kbyte block.
// - Three-bit storage key per 4-Kbyte block.
// - Three-bit user key per requester.
// - Keys written and read through key port.
// - Software initialises block and user keys.
// - Fill moves 16 bytes; writes sized.
// - 1024 rows, two sets; LRU updated.
`default_nettype none
module stc_cache (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire stc_pkg::stc_user_t cpu_user,
   input wire stc_pkg::stc_size_t cpu_size,
   input wire logic [stc_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic [stc_pkg::DATA_W-1:0] cpu_wdata,
   output logic cpu_rdy,
   output logic cpu_ack,
   output logic cpu_exc,
   output logic [stc_pkg::DATA_W-1:0] cpu_rdata,
   input wire logic [stc_pkg::KADDR_W-1:0] key_addr,
   input wire logic [stc_pkg::KDATA_W-1:0] key_wdata,
   input wire logic key_wr,
   input wire logic key_rd,
   output logic [stc_pkg::KDATA_W-1:0] key_rdata,
   stc_link_if.cache lk
);
   typedef enum {C_IDLE, C_CHECK, C_WAIT, C_BEAT} stc_cst_t;
   stc_cst_t st_ff;
   logic rdy_ff, ack_ff, exc_ff, req_ff, fill_ff, we_ff, way_ff;
   logic [stc_pkg::DATA_W-1:0] rdata_ff, wdata_ff;
   logic [stc_pkg::ADDR_W-1:0] addr_ff;
   stc_pkg::stc_user_t user_ff;
   stc_pkg::stc_size_t size_ff;
   logic [1:0] beat_ff;
   logic inv_pend_ff;
   logic [stc_pkg::ADDR_W-1:0] inv_addr_ff;
   logic [2:0] cause_ff;
   logic [stc_pkg::KDATA_W-1:0] key_rdata_ff;
   logic [stc_pkg::DATA_W-1:0] data_mem [0:stc_pkg::LINES*4-1];
   logic [stc_pkg::TAG_W-1:0] tag_mem [0:stc_pkg::LINES-1];
   logic [stc_pkg::LINES-1:0] valid_ff;
   logic [stc_pkg::ROWS-1:0] lru_ff;
   logic [stc_pkg::BLK4_N-1:0][stc_pkg::KEY_W-1:0] skey_ff;
   logic [stc_pkg::BLK4_N-1:0] ro_ff;
   logic [stc_pkg::BLK8_N-1:0] ae_ff;
   logic [stc_pkg::USERS-1:0][stc_pkg::KEY_W-1:0] ukey_ff;

   wire [stc_pkg::ROW_W-1:0] row = addr_ff[stc_pkg::ROW_LSB+:stc_pkg::ROW_W];
   wire [stc_pkg::TAG_W-1:0] tag = addr_ff[stc_pkg::TAG_LSB+:stc_pkg::TAG_W];
   wire [1:0] wsel = addr_ff[stc_pkg::WSEL_LSB+:2];
   wire hit0 = valid_ff[{1'b0, row}] && tag_mem[{1'b0, row}] == tag;
   wire hit1 = valid_ff[{1'b1, row}] && tag_mem[{1'b1, row}] == tag;
   wire hit = hit0 | hit1;
   wire [3:0] be = (size_ff == stc_pkg::STC_SZ_WORD) ? 4'hf :
                   (size_ff == stc_pkg::STC_SZ_HALF) ?
                   (addr_ff[1] ? 4'hc : 4'h3) :
                   (4'h1 << addr_ff[1:0]);
   wire [9:0] blk4 = addr_ff[stc_pkg::BLK4_LSB+:10];
   wire [8:0] blk8 = addr_ff[stc_pkg::BLK8_LSB+:9];
   wire is_fetch = user_ff == stc_pkg::STC_U_IFETCH;
   wire [stc_pkg::KEY_W-1:0] skey = skey_ff[blk4];
   wire [stc_pkg::KEY_W-1:0] ukey = ukey_ff[user_ff];
   wire ae_bad = !ae_ff[blk8];
   wire ro_bad = we_ff && ro_ff[blk4];
   wire key_bad = (we_ff || is_fetch) && skey != stc_pkg::SKEY_FREE &&
                  skey != ukey;
   wire [2:0] cause_set = {key_bad, ro_bad, ae_bad} &
                          {3{st_ff == C_CHECK}};
   wire exc = |cause_set;
   wire fill_ok = is_fetch || user_ff == stc_pkg::STC_U_PROG;
   wire victim = ~lru_ff[row];
   wire beat_done = (st_ff == C_BEAT) && lk.rvalid;
   wire fill_end = beat_done && fill_ff && beat_ff == stc_pkg::LAST_BEAT;
   wire wr_hit = (st_ff == C_CHECK) && !exc && we_ff && hit;
   wire rd_hit = (st_ff == C_CHECK) && !exc && !we_ff && hit;
   wire [stc_pkg::ROW_W-1:0] irow =
      inv_addr_ff[stc_pkg::ROW_LSB+:stc_pkg::ROW_W];
   wire [stc_pkg::TAG_W-1:0] itag =
      inv_addr_ff[stc_pkg::TAG_LSB+:stc_pkg::TAG_W];
   wire imatch0 = valid_ff[{1'b0, irow}] && tag_mem[{1'b0, irow}] == itag;
   wire imatch1 = valid_ff[{1'b1, irow}] && tag_mem[{1'b1, irow}] == itag;
   wire [1:0] ksel = key_addr[stc_pkg::KSEL_LSB+:2];
   wire [9:0] kidx = key_addr[9:0];
   wire [2:0] uidx = key_addr[2:0];
   wire ustat = uidx == stc_pkg::KIDX_STATUS;
   wire [2:0] cause_clr = (key_wr && ksel == stc_pkg::KSEL_USER && ustat) ?
                          key_wdata[2:0] : 3'h0;
   wire [stc_pkg::KDATA_W-1:0] key_rmux =
      (ksel == stc_pkg::KSEL_SKEY) ? {5'h0, skey_ff[kidx]} :
      (ksel == stc_pkg::KSEL_RO) ? {7'h0, ro_ff[kidx]} :
      (ksel == stc_pkg::KSEL_AE) ? {7'h0, ae_ff[kidx[8:0]]} :
      ustat ? {5'h0, cause_ff} :
      (uidx < 3'(stc_pkg::USERS)) ? {5'h0, ukey_ff[uidx]} : 8'h00;

   // The cache lets go of the bus at once when the controller claims it.
   assign lk.sad_c_oe_n = !(req_ff && !lk.inv_line);
   assign lk.sad_c = addr_ff;
   assign lk.req = req_ff;
   assign lk.we = we_ff;
   assign lk.fill = fill_ff;
   assign lk.be = be;
   assign lk.wdata = wdata_ff;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_ff <= C_IDLE;
         rdy_ff <= 1'b1;
         ack_ff <= 1'b0;
         exc_ff <= 1'b0;
         req_ff <= 1'b0;
         fill_ff <= 1'b0;
         we_ff <= 1'b0;
         way_ff <= 1'b0;
         beat_ff <= 2'h0;
         addr_ff <= '0;
         wdata_ff <= '0;
         rdata_ff <= '0;
         user_ff <= stc_pkg::STC_U_MAINT;
         size_ff <= stc_pkg::STC_SZ_WORD;
      end else begin
         ack_ff <= 1'b0;
         exc_ff <= 1'b0;
         case (st_ff)
            C_IDLE: begin
               if (cpu_req) begin
                  rdy_ff <= 1'b0;
                  we_ff <= cpu_we;
                  user_ff <= cpu_user;
                  size_ff <= cpu_size;
                  addr_ff <= cpu_addr;
                  wdata_ff <= cpu_wdata;
                  st_ff <= C_CHECK;
               end
            end
            C_CHECK: begin
               if (exc) begin
                  ack_ff <= 1'b1;
                  exc_ff <= 1'b1;
                  rdy_ff <= 1'b1;
                  st_ff <= C_IDLE;
               end else if (rd_hit) begin
                  rdata_ff <= data_mem[{hit1, row, wsel}];
                  ack_ff <= 1'b1;
                  rdy_ff <= 1'b1;
                  st_ff <= C_IDLE;
               end else begin
                  req_ff <= 1'b1;
                  fill_ff <= !we_ff && fill_ok;
                  way_ff <= victim;
                  beat_ff <= 2'h0;
                  st_ff <= C_WAIT;
               end
            end
            C_WAIT: begin
               if (lk.ack) begin
                  req_ff <= 1'b0;
                  if (we_ff) begin
                     ack_ff <= 1'b1;
                     rdy_ff <= 1'b1;
                     st_ff <= C_IDLE;
                  end else begin
                     st_ff <= C_BEAT;
                  end
               end
            end
            C_BEAT: begin
               if (lk.rvalid) begin
                  beat_ff <= beat_ff + 2'h1;
                  if (!fill_ff || beat_ff == wsel) begin
                     rdata_ff <= lk.rdata;
                  end
                  if (!fill_ff || beat_ff == stc_pkg::LAST_BEAT) begin
                     ack_ff <= 1'b1;
                     rdy_ff <= 1'b1;
                     st_ff <= C_IDLE;
                  end
               end
            end
            default: begin
               st_ff <= C_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (wr_hit) begin
         for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
               data_mem[{hit1, row, wsel}][8*i+:8] <= wdata_ff[8*i+:8];
            end
         end
      end
      if (beat_done && fill_ff) begin
         data_mem[{way_ff, row, beat_ff}] <= lk.rdata;
      end
      if (fill_end) begin
         tag_mem[{way_ff, row}] <= tag;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         valid_ff <= '0;
         lru_ff <= '0;
         inv_pend_ff <= 1'b0;
         inv_addr_ff <= '0;
      end else begin
         inv_pend_ff <= lk.inv_line;
         if (lk.inv_line) begin
            inv_addr_ff <= lk.shared_address_data_bus;
         end
         if (wr_hit || rd_hit) begin
            lru_ff[row] <= hit1;
         end
         if (fill_end) begin
            valid_ff[{way_ff, row}] <= 1'b1;
            lru_ff[row] <= way_ff;
         end
         // Invalidation is applied last but matches only old tags, so a fill ending in the same cycle survives it unless the victim way's old tag matches.
         if (inv_pend_ff) begin
            if (imatch0) begin
               valid_ff[{1'b0, irow}] <= 1'b0;
            end
            if (imatch1) begin
               valid_ff[{1'b1, irow}] <= 1'b0;
            end
            lru_ff[irow] <= !imatch1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         skey_ff <= {stc_pkg::BLK4_N{stc_pkg::SKEY_RST}};
         ro_ff <= {stc_pkg::BLK4_N{stc_pkg::RO_RST}};
         ae_ff <= {stc_pkg::BLK8_N{stc_pkg::AE_RST}};
         ukey_ff <= {stc_pkg::USERS{stc_pkg::UKEY_RST}};
         cause_ff <= 3'h0;
         key_rdata_ff <= 8'h00;
      end else begin
         cause_ff <= (cause_ff & ~cause_clr) | cause_set;
         key_rdata_ff <= key_rd ? key_rmux : 8'h00;
         if (key_wr) begin
            case (ksel)
               stc_pkg::KSEL_SKEY: skey_ff[kidx] <= key_wdata[2:0];
               stc_pkg::KSEL_RO: ro_ff[kidx] <= key_wdata[0];
               stc_pkg::KSEL_AE: ae_ff[kidx[8:0]] <= key_wdata[0];
               default: begin
                  if (uidx < 3'(stc_pkg::USERS)) begin
                     ukey_ff[uidx] <= key_wdata[2:0];
                  end
               end
            endcase
         end
      end
   end

   assign cpu_rdy = rdy_ff;
   assign cpu_ack = ack_ff;
   assign cpu_exc = exc_ff;
   assign cpu_rdata = rdata_ff;
   assign key_rdata = key_rdata_ff;
endmodule : stc_cache
`default_nettype wire

// ===== stc_pkg.sv
`default_nettype none
package stc_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 32;
   localparam int ROW_W = 10;
   localparam int TAG_W = 8;
   localparam int TAG_LSB = 14;
   localparam int ROW_LSB = 4;
   localparam int WSEL_LSB = 2;
   localparam int BLK4_LSB = 12;
   localparam int BLK8_LSB = 13;
   localparam int BLK4_N = 1024;
   localparam int BLK8_N = 512;
   localparam int ROWS = 1024;
   localparam int LINES = 2048;
   localparam int LINE_WORDS = 4;
   localparam int KEY_W = 3;
   localparam int USERS = 6;
   localparam int KADDR_W = 13;
   localparam int KSEL_LSB = 11;
   localparam int KDATA_W = 8;
   localparam logic [1:0] KSEL_SKEY = 2'h0;
   localparam logic [1:0] KSEL_RO = 2'h1;
   localparam logic [1:0] KSEL_AE = 2'h2;
   localparam logic [1:0] KSEL_USER = 2'h3;
   localparam logic [2:0] KIDX_STATUS = 3'h7;
   localparam int EXC_AE = 0;
   localparam int EXC_RO = 1;
   localparam int EXC_KEY = 2;
   localparam logic [KEY_W-1:0] SKEY_FREE = 3'h0;
   localparam logic [KEY_W-1:0] SKEY_RST = 3'h0;
   localparam logic [KEY_W-1:0] UKEY_RST = 3'h0;
   localparam logic RO_RST = 1'h0;
   localparam logic AE_RST = 1'h1;
   localparam logic [1:0] LAST_BEAT = 2'h3;
   typedef enum logic [2:0] {
      STC_U_MAINT,
      STC_U_TRACE,
      STC_U_IFETCH,
      STC_U_PROG,
      STC_U_ADAPTER
   } stc_user_t;
   typedef enum logic [1:0] {
      STC_SZ_BYTE,
      STC_SZ_HALF,
      STC_SZ_WORD
   } stc_size_t;
endpackage : stc_pkg
`default_nettype wire

// ===== stc_link_if.sv
`default_nettype none
interface stc_link_if;
   logic req;
   logic we;
   logic fill;
   logic [3:0] be;
   logic [stc_pkg::DATA_W-1:0] wdata;
   logic ack;
   logic rvalid;
   logic [stc_pkg::DATA_W-1:0] rdata;
   logic inv_line;
   logic [stc_pkg::ADDR_W-1:0] sad_c;
   logic sad_c_oe_n;
   logic [stc_pkg::ADDR_W-1:0] sad_s;
   logic sad_s_oe_n;
   logic [stc_pkg::ADDR_W-1:0] shared_address_data_bus;

   // Level seen on the shared address/data bus; idle bus reads as zero.
   assign shared_address_data_bus = !sad_c_oe_n ? sad_c :
                (!sad_s_oe_n ? sad_s : '0);

   modport cache (output req, output we, output fill, output be,
                  output wdata, output sad_c, output sad_c_oe_n,
                  input ack, input rvalid, input rdata, input inv_line,
                  input shared_address_data_bus);
   modport ctl (input req, input we, input fill, input be, input wdata,
                output ack, output rvalid, output rdata, output inv_line,
                output sad_s, output sad_s_oe_n, input shared_address_data_bus);
endinterface : stc_link_if
`default_nettype wire

// ===== stc_storage_ctl.sv
`default_nettype none
module stc_storage_ctl (
   input wire logic clk_sys,
   input wire logic rstn,
   stc_link_if.ctl lk,
   input wire logic dma_inv_req,
   input wire logic [stc_pkg::ADDR_W-1:0] dma_inv_addr,
   output logic dma_inv_busy,
   output logic mem_wr,
   output logic mem_rd,
   output logic [stc_pkg::ADDR_W-3:0] mem_addr,
   output logic [stc_pkg::DATA_W-1:0] mem_wdata,
   output logic [3:0] mem_be,
   input wire logic [stc_pkg::DATA_W-1:0] mem_rdata
);
   typedef enum {S_IDLE, S_INV, S_HOLD, S_ACKED, S_READ} stc_sst_t;
   stc_sst_t st_ff;
   logic pend_ff;
   logic [stc_pkg::ADDR_W-1:0] iaddr_ff;
   logic [stc_pkg::ADDR_W-3:0] base_ff;
   logic [1:0] beat_ff;
   logic [1:0] last_ff;
   logic rd_p_ff;
   logic ack_ff;
   logic rvalid_ff;
   logic [stc_pkg::DATA_W-1:0] rdata_ff;
   logic inv_ff;
   logic [stc_pkg::ADDR_W-1:0] sad_ff;
   logic oe_n_ff;
   logic mem_wr_ff;
   logic mem_rd_ff;
   logic [stc_pkg::ADDR_W-3:0] mem_addr_ff;
   logic [stc_pkg::DATA_W-1:0] mem_wdata_ff;
   logic [3:0] mem_be_ff;

   wire serve_inv = (st_ff == S_IDLE) && pend_ff;
   wire take_req = (st_ff == S_IDLE) && !pend_ff && lk.req;
   wire [stc_pkg::ADDR_W-3:0] word_addr = lk.shared_address_data_bus[stc_pkg::ADDR_W-1:2];
   wire [stc_pkg::ADDR_W-3:0] line_addr = {lk.shared_address_data_bus[stc_pkg::ADDR_W-1:4],
                                           2'h0};
   // A new invalidation arriving as the old one is served is kept.
   wire nxt_pend = dma_inv_req | (pend_ff & ~serve_inv);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pend_ff <= 1'b0;
         iaddr_ff <= '0;
      end else begin
         pend_ff <= nxt_pend;
         if (dma_inv_req) begin
            iaddr_ff <= dma_inv_addr;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_ff <= S_IDLE;
         ack_ff <= 1'b0;
         inv_ff <= 1'b0;
         oe_n_ff <= 1'b1;
         sad_ff <= '0;
         mem_wr_ff <= 1'b0;
         mem_rd_ff <= 1'b0;
         mem_addr_ff <= '0;
         mem_wdata_ff <= '0;
         mem_be_ff <= '0;
         base_ff <= '0;
         beat_ff <= '0;
         last_ff <= '0;
      end else begin
         ack_ff <= 1'b0;
         mem_wr_ff <= 1'b0;
         mem_rd_ff <= 1'b0;
         case (st_ff)
            S_IDLE: begin
               if (serve_inv) begin
                  inv_ff <= 1'b1;
                  sad_ff <= iaddr_ff;
                  oe_n_ff <= 1'b0;
                  st_ff <= S_INV;
               end else if (take_req) begin
                  ack_ff <= 1'b1;
                  if (lk.we) begin
                     mem_wr_ff <= 1'b1;
                     mem_addr_ff <= word_addr;
                     mem_wdata_ff <= lk.wdata;
                     mem_be_ff <= lk.be;
                     st_ff <= S_ACKED;
                  end else begin
                     base_ff <= lk.fill ? line_addr : word_addr;
                     last_ff <= lk.fill ? stc_pkg::LAST_BEAT : 2'h0;
                     beat_ff <= 2'h0;
                     st_ff <= S_READ;
                  end
               end
            end
            S_INV: begin
               inv_ff <= 1'b0;
               oe_n_ff <= 1'b1;
               st_ff <= S_HOLD;
            end
            S_HOLD: begin
               st_ff <= S_IDLE;
            end
            S_ACKED: begin
               st_ff <= S_IDLE;
            end
            S_READ: begin
               mem_rd_ff <= 1'b1;
               mem_addr_ff <= base_ff + {{(stc_pkg::ADDR_W-4){1'b0}}, beat_ff};
               beat_ff <= beat_ff + 2'h1;
               if (beat_ff == last_ff) begin
                  st_ff <= S_IDLE;
               end
            end
            default: begin
               st_ff <= S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rd_p_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
      end else begin
         rd_p_ff <= mem_rd_ff;
         rvalid_ff <= rd_p_ff;
         if (rd_p_ff) begin
            rdata_ff <= mem_rdata;
         end
      end
   end

   assign lk.ack = ack_ff;
   assign lk.rvalid = rvalid_ff;
   assign lk.rdata = rdata_ff;
   assign lk.inv_line = inv_ff;
   assign lk.sad_s = sad_ff;
   assign lk.sad_s_oe_n = oe_n_ff;
   assign dma_inv_busy = pend_ff;
   assign mem_wr = mem_wr_ff;
   assign mem_rd = mem_rd_ff;
   assign mem_addr = mem_addr_ff;
   assign mem_wdata = mem_wdata_ff;
   assign mem_be = mem_be_ff;
endmodule : stc_storage_ctl
`default_nettype wire

// ===== stc_checker.sv
`default_nettype none
module stc_checker (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic req,
   input wire logic we,
   input wire logic fill,
   input wire logic ack,
   input wire logic rvalid,
   input wire logic inv_line,
   input wire logic [stc_pkg::ADDR_W-1:0] sad_c,
   input wire logic sad_c_oe_n,
   input wire logic [stc_pkg::ADDR_W-1:0] sad_s,
   input wire logic sad_s_oe_n,
   input wire logic [stc_pkg::ADDR_W-1:0] shared_address_data_bus
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   AST_INV_OWNER: assert property (
      inv_line |-> sad_c_oe_n && !sad_s_oe_n && shared_address_data_bus == sad_s)
      else $error("cache drove bus in invalidation");
   AST_REQ_DRIVE: assert property (
      req && !inv_line |-> !sad_c_oe_n && shared_address_data_bus == sad_c)
      else $error("request address not on bus");
   AST_INV_QUIET: assert property (
      inv_line |=> !ack [*2])
      else $error("request taken around invalidation");
   AST_INV_PULSE: assert property (
      inv_line |=> !inv_line)
      else $error("invalidation longer than a cycle");
   AST_ACK_CAUSE: assert property (
      ack |-> $past(req))
      else $error("ack without request");
   AST_REQ_HOLD: assert property (
      req && !ack |=> req)
      else $error("request dropped before ack");
   AST_WR_NOFILL: assert property (
      req && we |-> !fill)
      else $error("write asked for a fill");
   AST_WR_NODATA: assert property (
      ack && we |=> !rvalid [*4])
      else $error("read data after write");
   AST_FILL_BEATS: assert property (
      ack && fill |-> ##3 rvalid [*4] ##1 !rvalid)
      else $error("fill not four beats");
   cover property (ack && fill);
   cover property (ack && we);
   cover property (inv_line && req);
   cover property (ack && !we && !fill);
endmodule : stc_checker
`default_nettype wire

// ===== stc_tb_top.sv
`default_nettype none
module stc_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic cpu_req = 1'b0;
   logic cpu_we = 1'b0;
   stc_pkg::stc_user_t cpu_user = stc_pkg::STC_U_MAINT;
   stc_pkg::stc_size_t cpu_size = stc_pkg::STC_SZ_WORD;
   logic [21:0] cpu_addr = 22'h00_0000;
   logic [31:0] cpu_wdata = 32'h0000_0000;
   logic cpu_rdy;
   logic cpu_ack;
   logic cpu_exc;
   logic [31:0] cpu_rdata;
   logic [12:0] key_addr = 13'h0000;
   logic [7:0] key_wdata = 8'h00;
   logic key_wr = 1'b0;
   logic key_rd = 1'b0;
   logic [7:0] key_rdata;
   logic dma_inv_req = 1'b0;
   logic [21:0] dma_inv_addr = 22'h00_0000;
   logic dma_inv_busy;
   logic mem_wr;
   logic mem_rd;
   logic [19:0] mem_addr;
   logic [31:0] mem_wdata;
   logic [3:0] mem_be;
   logic [31:0] mem_rdata = 32'h0000_0000;
   logic [31:0] mem [int];
   logic [31:0] ref_mem [int];
   logic [31:0] w;
   bit vld [1024];
   int skey [4];
   int ro [4];
   int ukey [6];
   int seed = 50;
   int n_rd;
   int n_wr;
   int n_mismatch = 0;
   int num_checks = 0;

   stc_link_if lk ();
   stc_cache u_stc_cache (.clk_sys, .rstn, .cpu_req, .cpu_we, .cpu_user,
      .cpu_size, .cpu_addr, .cpu_wdata, .cpu_rdy, .cpu_ack, .cpu_exc,
      .cpu_rdata, .key_addr, .key_wdata, .key_wr, .key_rd, .key_rdata,
      .lk(lk));
   stc_storage_ctl u_stc_storage_ctl (.clk_sys, .rstn, .lk(lk),
      .dma_inv_req, .dma_inv_addr, .dma_inv_busy, .mem_wr, .mem_rd,
      .mem_addr, .mem_wdata, .mem_be, .mem_rdata);
   stc_checker u_stc_checker (.clk_sys, .rstn, .req(lk.req), .we(lk.we),
      .fill(lk.fill), .ack(lk.ack), .rvalid(lk.rvalid),
      .inv_line(lk.inv_line), .sad_c(lk.sad_c), .sad_c_oe_n(lk.sad_c_oe_n),
      .sad_s(lk.sad_s), .sad_s_oe_n(lk.sad_s_oe_n), .shared_address_data_bus(lk.shared_address_data_bus));

   always #10 clk_sys = ~clk_sys;

   function automatic logic [31:0] rd_w(input int a, input bit r);
      if (r && ref_mem.exists(a)) return ref_mem[a];
      if (!r && mem.exists(a)) return mem[a];
      return 32'h5A00_0000 ^ 32'(a * 7);
   endfunction : rd_w

   // Storage data toggles when not answering, so stale data never passes.
   always @(posedge clk_sys) begin
      mem_rdata <= mem_rd ? rd_w(int'(mem_addr), 1'b0) : ~mem_rdata;
      n_rd += int'(mem_rd);
      n_wr += int'(mem_wr);
      if (mem_wr) begin
         w = rd_w(int'(mem_addr), 1'b0);
         for (int i = 0; i < 4; i++)
            if (mem_be[i]) w[8*i +: 8] = mem_wdata[8*i +: 8];
         mem[int'(mem_addr)] = w;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   task automatic kwr(input int s, input int i, input int d);
      @(posedge clk_sys);
      key_addr <= 13'(s * 2048 + i);
      key_wdata <= 8'(d);
      key_wr <= 1'b1;
      @(posedge clk_sys);
      key_wr <= 1'b0;
   endtask : kwr

   task automatic kchk(input int s, input int i, input int d);
      @(posedge clk_sys);
      key_addr <= 13'(s * 2048 + i);
      key_rd <= 1'b1;
      @(posedge clk_sys);
      key_rd <= 1'b0;
      @(negedge clk_sys);
      check(key_rdata, d);
      @(negedge clk_sys);
      check(key_rdata, 32'h0000_0000);
   endtask : kchk

   // One processor access, optionally racing an invalidation of its line.
   task automatic op(input bit wr, input int u, input int sz, input int a,
                     input bit inv);
      int t;
      int ex;
      int row;
      int blk;
      bit hit;
      bit fl;
      logic [31:0] wd;
      logic [31:0] e;
      row = (a >> 4) % 1024;
      blk = a >> 12;
      hit = vld[row] && blk < 4;
      fl = !wr && (u == 2 || u == 3);
      ex = 0;
      if (blk > 3)
         ex = 1;
      else if (wr && ro[blk] != 0)
         ex = 2;
      else if ((wr || u == 2) && skey[blk] != 0 && skey[blk] != ukey[u])
         ex = 4;
      wd = $random(seed);
      n_rd = 0;
      n_wr = 0;
      @(posedge clk_sys);
      cpu_req <= 1'b1;
      cpu_we <= wr;
      cpu_user <= stc_pkg::stc_user_t'(u);
      cpu_size <= stc_pkg::stc_size_t'(sz);
      cpu_addr <= 22'(a);
      cpu_wdata <= wd;
      dma_inv_req <= inv;
      dma_inv_addr <= 22'(a);
      @(posedge clk_sys);
      cpu_req <= 1'b0;
      dma_inv_req <= 1'b0;
      @(negedge clk_sys);
      check(cpu_rdy, 1'b0);
      if (inv) check(dma_inv_busy, 1'b1);
      t = 1;
      do begin
         @(negedge clk_sys);
         t++;
      end while (cpu_ack !== 1'b1 && t < 100);
      check(t < 100, 1);
      check(cpu_rdy, 1'b1);
      check(cpu_exc, ex != 0);
      if (!wr && ex == 0) check(cpu_rdata, rd_w(a >> 2, 1'b1));
      repeat (6) @(posedge clk_sys);
      check(n_rd, (wr || hit || ex != 0) ? 0 : (fl ? 4 : 1));
      check(n_wr, wr && ex == 0);
      if (ex != 0) begin
         kchk(3, 7, ex);
         kwr(3, 7, 7);
      end else if (wr) begin
         e = rd_w(a >> 2, 1'b1);
         for (int i = 0; i < 4; i++)
            if (sz == 2 || (sz == 1 && i / 2 == a / 2 % 2) || i == a % 4)
               e[8*i +: 8] = wd[8*i +: 8];
         ref_mem[a >> 2] = e;
      end else if (fl) begin
         vld[row] = 1'b1;
      end
      if (inv && blk < 4) vld[row] = fl && !hit && ex == 0;
   endtask : op

   initial begin
      int a;
      int sz;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      kchk(0, 1, 0);
      kchk(1, 2, 0);
      kchk(2, 2, 1);
      kchk(3, 7, 0);
      skey = '{0, 1 + $unsigned($random(seed)) % 7, 0, 0};
      ro = '{0, 0, 1, 0};
      kwr(0, 1, skey[1]);
      kwr(1, 2, 1);
      kwr(2, 2, 0);
      for (int u = 0; u < 6; u++) begin
         ukey[u] = u == 3 ? skey[1] :
                   (u == 2 ? skey[1] ^ 1 : $random(seed) & 7);
         kchk(3, u, 0);
         kwr(3, u, ukey[u]);
         kchk(3, u, ukey[u]);
      end
      kchk(0, 1, skey[1]);
      $display("key test done");
      op(1, 0, 2, 16'h0100, 0);
      op(0, 0, 2, 16'h0100, 0);
      op(0, 3, 2, 16'h0100, 0);
      op(0, 0, 0, 16'h0103, 0);
      op(1, 4, 1, 16'h0102, 0);
      op(0, 2, 2, 16'h0100, 0);
      op(1, 1, 0, 16'h0101, 1);
      op(0, 1, 2, 16'h0100, 0);
      op(0, 2, 2, 16'h0100, 0);
      op(1, 3, 2, 16'h1000, 0);
      op(1, 0, 2, 16'h1004, 0);
      op(0, 2, 2, 16'h1008, 0);
      op(1, 3, 2, 16'h2000, 0);
      op(0, 2, 2, 16'h2010, 0);
      op(0, 4, 2, 16'h4000, 0);
      op(1, 4, 2, 16'h5FFC, 0);
      $display("directed test done");
      for (int k = 0; k < 100; k++) begin
         sz = $unsigned($random(seed)) % 3;
         a = $random(seed) & 32'h0000_7C3F & ~((1 << sz) - 1);
         if (a >= 32'h0000_6000) a -= 32'h0000_2000;
         op(bit'($random(seed)), $unsigned($random(seed)) % 5, sz, a,
            ($random(seed) & 7) == 0);
      end
      foreach (ref_mem[k]) check(rd_w(k, 1'b0), ref_mem[k]);
      $display("random test done");
      close_out();
   end

   initial begin
      #600_000;
      n_mismatch++;
      close_out();
   end
endmodule : stc_tb_top
`default_nettype wire
